//--- design/mtr_defines.svh
`ifndef MTR_DEFINES_SVH
`define MTR_DEFINES_SVH

// Memory type encodings shared by range and attribute fields
`define MT_UC       3'h0
`define MT_WC       3'h1
`define MT_WT       3'h4
`define MT_WP       3'h5
`define MT_WB       3'h6
`define MT_UCM      3'h7

// Attribute table layout: eight fields, one per byte
`define PAT_FIELDS  8
`define PAT_STRIDE  8
`define PAT_TYPE_W  3
`define PAT_RESET   64'h0007040600070406

// Number of variable ranges reported by the lookup
`define VAR_RANGES  8

`endif

//--- design/mtr_pkg.sv
package mtr_pkg;

	// Three-bit memory type code
	typedef logic [2:0] mem_type_type;

	// Access policy derived from the effective type
	typedef struct packed {
		logic cacheable;
		logic wc_allowed;
		logic spec_allowed;
		logic rd_alloc;
		logic rd_alloc_excl;
		logic wr_alloc;
		logic wr_hit_cache;
		logic wr_hit_inval;
		logic wr_mem;
	} access_attr_type;

endpackage

//--- design/type_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries merged range type and policy between resolver parts
interface type_link_if;
	import mtr_pkg::*;

	mem_type_type    range_type;
	logic            range_undef;
	mem_type_type    eff_type;
	access_attr_type attr;

	modport merge_mp  (output range_type, output range_undef);
	modport policy_mp (input eff_type, output attr);
	modport top_mp    (input range_type, input range_undef, input attr, output eff_type);
endinterface

`default_nettype wire

//--- design/range_merge.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.svh"

module range_merge
	import mtr_pkg::*;
(
	// Clock and reset, used by checks only
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Range lookup results
	input  wire logic        range_enable,
	input  wire logic        fixed_enable,
	input  wire logic        fixed_hit,
	input  wire logic [2:0]  fixed_type,
	input  wire logic [7:0]  var_hit,
	input  wire logic [23:0] var_type,
	input  wire logic [2:0]  default_type,
	// Merged type
	type_link_if.merge_mp    lnk
);

	logic         seen;
	logic         same;
	logic         any_uc;
	logic         only_wtwb;
	mem_type_type first_type;
	mem_type_type cur;

	// Scan hitting variable ranges, lowest index first
	always_comb begin
		seen       = 1'b0;
		same       = 1'b1;
		any_uc     = 1'b0;
		only_wtwb  = 1'b1;
		first_type = `MT_UC;
		cur        = `MT_UC;
		for (int i = 0; i < `VAR_RANGES; i++) begin
			cur = var_type[3*i +: 3];
			if (var_hit[i]) begin
				if (!seen) begin
					first_type = cur;
				end
				if (seen && cur != first_type) begin
					same = 1'b0;
				end
				if (cur == `MT_UC) begin
					any_uc = 1'b1;
				end
				if (cur != `MT_WT && cur != `MT_WB) begin
					only_wtwb = 1'b0;
				end
				seen = 1'b1;
			end
		end
	end

	// Precedence: disabled, fixed, default, then overlap rules
	always_comb begin
		lnk.range_undef = 1'b0;
		if (!range_enable) begin
			lnk.range_type = `MT_UC;
		// RULE7: fixed wins
		end else if (fixed_enable && fixed_hit) begin
			lnk.range_type = fixed_type;
		end else if (!seen) begin
			lnk.range_type = default_type;
		// RULE9: any uncacheable
		end else if (any_uc) begin
			lnk.range_type = `MT_UC;
		// RULE8: identical types
		end else if (same) begin
			lnk.range_type = first_type;
		// RULE10: write-through mix
		end else if (only_wtwb) begin
			lnk.range_type = `MT_WT;
		// RULE11: undefined mix
		end else begin
			lnk.range_type  = `MT_UC; // Safest pick for an undefined mix
			lnk.range_undef = 1'b1;
		end
	end

	property p_fixed_first;
		@(posedge ref_clk) disable iff (!resetn)
		range_enable && fixed_enable && fixed_hit |-> lnk.range_type == fixed_type && !lnk.range_undef;
	endproperty
	a_fixed_first: assert property (p_fixed_first) else $error("fixed range lost precedence"); // RULE7

	property p_any_uc;
		@(posedge ref_clk) disable iff (!resetn)
		range_enable && !(fixed_enable && fixed_hit) && |var_hit && any_uc |-> lnk.range_type == `MT_UC;
	endproperty
	a_any_uc: assert property (p_any_uc) else $error("overlap with uncacheable not uncacheable"); // RULE9

	property p_wt_mix;
		@(posedge ref_clk) disable iff (!resetn)
		range_enable && !(fixed_enable && fixed_hit) && seen && only_wtwb |-> lnk.range_type == `MT_WT
			|| (same && lnk.range_type == first_type);
	endproperty
	a_wt_mix: assert property (p_wt_mix) else $error("write-through mix not resolved"); // RULE10

endmodule // range_merge

`default_nettype wire

//--- design/type_policy.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.svh"

module type_policy
	import mtr_pkg::*;
(
	// Clock and reset, used by checks only
	input  wire logic      ref_clk,
	input  wire logic      resetn,
	// Effective type in, policy out
	type_link_if.policy_mp lnk
);

	// Map each type to its allocation and write behaviour
	always_comb begin
		lnk.attr        = '0;
		lnk.attr.wr_mem = 1'b1;
		case (lnk.eff_type)
			// RULE21: combining, speculative reads
			`MT_WC: begin
				lnk.attr.wc_allowed   = 1'b1;
				lnk.attr.spec_allowed = 1'b1;
			end
			// RULE22: shared fill, no write allocate
			`MT_WT: begin
				lnk.attr.cacheable    = 1'b1;
				lnk.attr.spec_allowed = 1'b1;
				lnk.attr.rd_alloc     = 1'b1;
				lnk.attr.wr_hit_cache = 1'b1;
			end
			// RULE23: write hits invalidate
			`MT_WP: begin
				lnk.attr.cacheable    = 1'b1;
				lnk.attr.spec_allowed = 1'b1;
				lnk.attr.rd_alloc     = 1'b1;
				lnk.attr.wr_hit_inval = 1'b1;
			end
			// RULE24: exclusive fill, modified allocate
			`MT_WB: begin
				lnk.attr.cacheable     = 1'b1;
				lnk.attr.spec_allowed  = 1'b1;
				lnk.attr.rd_alloc      = 1'b1;
				lnk.attr.rd_alloc_excl = 1'b1;
				lnk.attr.wr_alloc      = 1'b1;
				lnk.attr.wr_hit_cache  = 1'b1;
				lnk.attr.wr_mem        = 1'b0;
			end
			// RULE21: strictly uncached
			default: begin
				lnk.attr.wr_mem = 1'b1;
			end
		endcase
	end

	property p_uc_strict;
		@(posedge ref_clk) disable iff (!resetn)
		(lnk.eff_type == `MT_UC || lnk.eff_type == `MT_UCM)
			|-> !lnk.attr.wc_allowed && !lnk.attr.spec_allowed && !lnk.attr.cacheable;
	endproperty
	a_uc_strict: assert property (p_uc_strict) else $error("uncacheable allows combining"); // RULE21

	property p_wb_alloc;
		@(posedge ref_clk) disable iff (!resetn)
		lnk.eff_type == `MT_WB |-> lnk.attr.wr_alloc && lnk.attr.rd_alloc_excl && !lnk.attr.wr_mem;
	endproperty
	a_wb_alloc: assert property (p_wb_alloc) else $error("write-back lacks allocation"); // RULE24

endmodule // type_policy

`default_nettype wire

//--- design/memory_type_resolver.sv
// What this block does
// RULE1: Caching on, both page bits clear: range type is effective.
// RULE2: Caching on, page cache-disable set: result is uncacheable; a combining range with write-through clear stays combining.
// RULE3: Write-through page takes range type, demoting write-back to write-through.
// RULE4: Write-combining range stays so unless both page bits set.
// RULE5: Differing ranges inside one large page give an undefined type.
// RULE6: Software should avoid differently typed ranges under one large page.
// RULE7: Fixed ranges win over any variable range.
// RULE8: Overlapping variable ranges of one type keep that type.
// RULE9: Any uncacheable overlap gives uncacheable.
// RULE10: Overlap of write-through and write-back only gives write-through.
// RULE11: Any other overlap mix is undefined.
// RULE12: Software keeps all processors' settings identical; no check here.
// RULE13: Holds a 64-bit attribute table of eight type fields.
// RULE14: Field n sits in low three bits of byte n.
// RULE15: Field codes follow the shared memory type encodings.
// RULE16: Uncacheable-minus acts as uncacheable unless range is write-combining.
// RULE17: Nonzero reserved bits on write fault and keep register.
// RULE18: Unsupported field encoding on write faults.
// RULE19: Reset loads write-back, write-through, uncacheable-minus, uncacheable twice.
// RULE20: Index is attribute bit, cache-disable, write-through, high to low.
// RULE21: Uncacheable forbids combining and speculation; combining allows both.
// RULE22: Write-through fills shared, no write allocate, hits update both.
// RULE23: Write-protect fills shared, writes to memory, hits invalidate.
// RULE24: Write-back fills shared or exclusive, write misses allocate modified.
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.svh"

module memory_type_resolver
	import mtr_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Attribute table access
	input  wire logic        pat_wr_en,
	input  wire logic [63:0] pat_wr_data,
	output logic      [63:0] pat_rd_data,
	output logic             protection_fault,
	// Global cache controls
	input  wire logic        global_cache_disable,
	input  wire logic        global_no_write_through,
	// Range lookup results
	input  wire logic        range_enable,
	input  wire logic        fixed_enable,
	input  wire logic        fixed_hit,
	input  wire logic [2:0]  fixed_type,
	input  wire logic [7:0]  var_hit,
	input  wire logic [23:0] var_type,
	input  wire logic [2:0]  default_type,
	input  wire logic        range_split,
	// Page request from translation
	input  wire logic        req_valid,
	input  wire logic        page_attr_index_bit,
	input  wire logic        page_cache_disable_bit,
	input  wire logic        page_write_through_bit,
	// Resolved answer
	output logic             rsp_valid,
	output logic [2:0]       eff_type,
	output logic             type_undefined,
	output access_attr_type  access_attr
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Reserved part of one table byte
	function automatic logic byte_reserved_bad(input logic [7:0] b);
		byte_reserved_bad = |b[7:`PAT_TYPE_W];
	endfunction

	// Encodings 2 and 3 have no meaning in a field
	function automatic logic byte_enc_bad(input logic [7:0] b);
		byte_enc_bad = (b[2:0] != `MT_UC) && (b[2:0] != `MT_WC) && (b[2:0] < `MT_WT);
	endfunction

	// Merge attribute type with range type
	function automatic mem_type_type combine(input mem_type_type pat_t, input mem_type_type rng_t);
		combine = `MT_UC;
		case (pat_t)
			`MT_UC:  combine = `MT_UC;
			`MT_UCM: combine = (rng_t == `MT_WC) ? `MT_WC : `MT_UC;
			`MT_WC:  combine = `MT_WC;
			`MT_WP: begin
				if (rng_t == `MT_WP || rng_t == `MT_WB) begin
					combine = `MT_WP;
				end
			end
			`MT_WT:  combine = (rng_t == `MT_WB) ? `MT_WT : rng_t;
			`MT_WB:  combine = rng_t;
			default: combine = `MT_UC;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sub-blocks

	type_link_if lnk ();

	range_merge u_merge (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.range_enable (range_enable),
		.fixed_enable (fixed_enable),
		.fixed_hit    (fixed_hit),
		.fixed_type   (fixed_type),
		.var_hit      (var_hit),
		.var_type     (var_type),
		.default_type (default_type),
		.lnk          (lnk.merge_mp)
	);

	type_policy u_policy (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.lnk     (lnk.policy_mp)
	);

	////////////////////////////////////////////////////////////////////////
	// Attribute table register

	logic [63:0] pat_ff;
	logic [63:0] nxt_pat;
	logic        fault_ff;
	logic        nxt_fault;
	logic [7:0]  res_bad;
	logic [7:0]  enc_bad;

	// RULE14: per-byte field check
	genvar gi;
	generate
		for (gi = 0; gi < `PAT_FIELDS; gi++) begin : g_chk
			assign res_bad[gi] = byte_reserved_bad(pat_wr_data[`PAT_STRIDE*gi +: `PAT_STRIDE]);
			assign enc_bad[gi] = byte_enc_bad(pat_wr_data[`PAT_STRIDE*gi +: `PAT_STRIDE]);
		end
	endgenerate

	// A faulting write is dropped whole, so no field is half updated
	always_comb begin
		nxt_pat   = pat_ff;
		nxt_fault = 1'b0;
		if (pat_wr_en) begin
			// RULE17: reserved bits fault
			// RULE18: bad encoding faults
			if (|res_bad || |enc_bad) begin
				nxt_fault = 1'b1;
			// RULE13: store full register
			end else begin
				nxt_pat = pat_wr_data;
			end
		end
	end

	// RULE19: default field pattern
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pat_ff   <= `PAT_RESET;
			fault_ff <= 1'b0;
		end else begin
			pat_ff   <= nxt_pat;
			fault_ff <= nxt_fault;
		end
	end

	assign pat_rd_data      = pat_ff;
	assign protection_fault = fault_ff;

	////////////////////////////////////////////////////////////////////////
	// Type resolution

	logic [2:0]   pat_idx;
	mem_type_type pat_field;
	logic         cache_on;
	logic         nxt_undef;

	// RULE20: index from page bits
	assign pat_idx = {page_attr_index_bit, page_cache_disable_bit, page_write_through_bit};
	// RULE15: field holds the type code
	assign pat_field = pat_ff[`PAT_STRIDE*pat_idx +: `PAT_TYPE_W];
	// Any setting other than both global bits clear disables caching
	assign cache_on = !global_cache_disable && !global_no_write_through;

	// RULE1: range type passes through
	// RULE2: cache-disable page
	// RULE3: write-back demoted
	// RULE4: combining survives
	// RULE16: minus yields to combining
	always_comb begin
		if (cache_on) begin
			lnk.eff_type = combine(pat_field, lnk.range_type);
		end else begin
			lnk.eff_type = `MT_UC;
		end
	end

	// RULE5: split large page
	// RULE11: undefined overlap
	assign nxt_undef = cache_on && (lnk.range_undef || range_split);

	////////////////////////////////////////////////////////////////////////
	// Answer registers

	logic            rsp_valid_ff;
	logic            nxt_rsp_valid;
	mem_type_type    eff_type_ff;
	mem_type_type    nxt_eff_type;
	logic            undef_ff;
	logic            nxt_undef_q;
	access_attr_type attr_ff;
	access_attr_type nxt_attr;

	// Answer is held between requests so the consumer may sample late
	always_comb begin
		nxt_rsp_valid = req_valid;
		nxt_eff_type  = eff_type_ff;
		nxt_undef_q   = undef_ff;
		nxt_attr      = attr_ff;
		if (req_valid) begin
			nxt_eff_type = lnk.eff_type;
			nxt_undef_q  = nxt_undef;
			nxt_attr     = lnk.attr;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rsp_valid_ff <= 1'b0;
			eff_type_ff  <= `MT_UC;
			undef_ff     <= 1'b0;
			attr_ff      <= '0;
		end else begin
			rsp_valid_ff <= nxt_rsp_valid;
			eff_type_ff  <= nxt_eff_type;
			undef_ff     <= nxt_undef_q;
			attr_ff      <= nxt_attr;
		end
	end

	assign rsp_valid      = rsp_valid_ff;
	assign eff_type       = eff_type_ff;
	assign type_undefined = undef_ff;
	assign access_attr    = attr_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_pat_reset;
		@(posedge ref_clk) disable iff (!resetn)
		$rose(resetn) |-> pat_ff == `PAT_RESET;
	endproperty
	a_pat_reset: assert property (p_pat_reset) else $error("table not at reset pattern"); // RULE19

	property p_res_fault;
		@(posedge ref_clk) disable iff (!resetn)
		pat_wr_en && |res_bad |=> protection_fault && $stable(pat_rd_data);
	endproperty
	a_res_fault: assert property (p_res_fault) else $error("reserved write not faulted"); // RULE17

	property p_enc_fault;
		@(posedge ref_clk) disable iff (!resetn)
		pat_wr_en && |enc_bad |=> protection_fault ##1 !protection_fault || $past(pat_wr_en);
	endproperty
	a_enc_fault: assert property (p_enc_fault) else $error("bad encoding not faulted"); // RULE18

	property p_good_write;
		@(posedge ref_clk) disable iff (!resetn)
		pat_wr_en && !(|res_bad) && !(|enc_bad) |=> pat_rd_data == $past(pat_wr_data) && !protection_fault;
	endproperty
	a_good_write: assert property (p_good_write) else $error("legal write not stored"); // RULE13

	property p_wb_page;
		@(posedge ref_clk) disable iff (!resetn)
		req_valid && cache_on && pat_ff == `PAT_RESET && pat_idx == 3'h0
			|=> rsp_valid && eff_type == $past(lnk.range_type);
	endproperty
	a_wb_page: assert property (p_wb_page) else $error("plain page did not take range type"); // RULE1

	property p_cd_page;
		@(posedge ref_clk) disable iff (!resetn)
		req_valid && cache_on && pat_ff == `PAT_RESET && page_cache_disable_bit
			&& (page_write_through_bit || lnk.range_type != `MT_WC) |=> eff_type == `MT_UC;
	endproperty
	a_cd_page: assert property (p_cd_page) else $error("cache-disable page not uncacheable"); // RULE2

	property p_wt_demote;
		@(posedge ref_clk) disable iff (!resetn)
		req_valid && cache_on && pat_ff == `PAT_RESET && pat_idx == 3'h1 && lnk.range_type == `MT_WB
			|=> eff_type == `MT_WT;
	endproperty
	a_wt_demote: assert property (p_wt_demote) else $error("write-back not demoted"); // RULE3

	property p_wc_keep;
		@(posedge ref_clk) disable iff (!resetn)
		req_valid && cache_on && pat_ff == `PAT_RESET && !page_cache_disable_bit && lnk.range_type == `MT_WC
			|=> eff_type == `MT_WC ##1 (rsp_valid || eff_type == `MT_WC);
	endproperty
	a_wc_keep: assert property (p_wc_keep) else $error("combining range lost"); // RULE4

	property p_minus;
		@(posedge ref_clk) disable iff (!resetn)
		req_valid && cache_on && pat_field == `MT_UCM
			|=> eff_type == ($past(lnk.range_type) == `MT_WC ? `MT_WC : `MT_UC);
	endproperty
	a_minus: assert property (p_minus) else $error("minus type misresolved"); // RULE16

endmodule // memory_type_resolver

`default_nettype wire

//--- dv/translation_unit_model.sv
`timescale 1ns/1ps
`default_nettype none

// Translation side: presents page bits for one request and takes the answer
module translation_unit_model
	import mtr_pkg::*;
(
	// Clock
	input  wire logic            ref_clk,
	// Page request
	output logic                 req_valid,
	output logic                 page_attr_index_bit,
	output logic                 page_cache_disable_bit,
	output logic                 page_write_through_bit,
	// Answer
	input  wire logic            rsp_valid,
	input  wire logic [2:0]      eff_type,
	input  wire logic            type_undefined,
	input  wire access_attr_type access_attr
);

	// Idle at time zero
	initial begin
		req_valid = 1'b0;
		{page_attr_index_bit, page_cache_disable_bit, page_write_through_bit} = 3'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One request; answer is taken 1 ns after the taking edge
	// index bits as given
	task automatic issue(input logic [2:0] idx, output logic [2:0] typ, output logic und,
		output logic [8:0] at, output logic ok);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		{page_attr_index_bit, page_cache_disable_bit, page_write_through_bit} <= idx;
		@(posedge ref_clk);
		// Bits carry no meaning past the taking edge, so show their inverse
		req_valid <= 1'b0;
		{page_attr_index_bit, page_cache_disable_bit, page_write_through_bit} <= ~idx;
		#1;
		ok = rsp_valid;
		typ = eff_type;
		und = type_undefined;
		at = access_attr;
	endtask

endmodule // translation_unit_model

`default_nettype wire

//--- dv/memory_type_resolver_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.svh"

module memory_type_resolver_bench
	import mtr_pkg::*;
;
	// Design side signals
	logic            ref_clk = 1'b0;
	logic            resetn = 1'b0;
	logic            pat_wr_en = 1'b0;
	logic [63:0]     pat_wr_data = 64'h0;
	logic [63:0]     pat_rd_data;
	logic            protection_fault;
	logic            global_cache_disable = 1'b0;
	logic            global_no_write_through = 1'b0;
	logic            range_enable = 1'b0;
	logic            fixed_enable = 1'b0;
	logic            fixed_hit = 1'b0;
	logic [2:0]      fixed_type = 3'h0;
	logic [7:0]      var_hit = 8'h0;
	logic [23:0]     var_type = 24'h0;
	logic [2:0]      default_type = 3'h0;
	logic            range_split = 1'b0;
	logic            req_valid;
	logic            page_attr_index_bit;
	logic            page_cache_disable_bit;
	logic            page_write_through_bit;
	logic            rsp_valid;
	logic [2:0]      eff_type;
	logic            type_undefined;
	access_attr_type access_attr;
	int              mismatches = 0;
	int              checked = 0;
	int              cycles = 0;
	// Default table after reset, fields zero to three
	logic [2:0]      dp [4] = '{`MT_WB, `MT_WT, `MT_UCM, `MT_UC};
	// Table used by the write scenario, fields zero to seven
	logic [2:0]      fp [8] = '{`MT_WB, `MT_UC, `MT_WC, `MT_WT, `MT_WP, `MT_WB, `MT_UCM, `MT_UC};
	logic [2:0]      rt [5] = '{`MT_UC, `MT_WC, `MT_WP, `MT_WT, `MT_WB};

	memory_type_resolver memory_type_resolver_inst (.ref_clk, .resetn, .pat_wr_en, .pat_wr_data, .pat_rd_data,
		.protection_fault, .global_cache_disable, .global_no_write_through, .range_enable, .fixed_enable,
		.fixed_hit, .fixed_type, .var_hit, .var_type, .default_type, .range_split, .req_valid,
		.page_attr_index_bit, .page_cache_disable_bit, .page_write_through_bit, .rsp_valid, .eff_type,
		.type_undefined, .access_attr);

	translation_unit_model translation_unit_model_inst (.ref_clk, .req_valid, .page_attr_index_bit,
		.page_cache_disable_bit, .page_write_through_bit, .rsp_valid, .eff_type, .type_undefined, .access_attr);

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Expected page and range combination
	function automatic logic [2:0] comb(input logic [2:0] p, input logic [2:0] r);
		case (p)
			`MT_UC: return `MT_UC;
			`MT_UCM: return (r == `MT_WC) ? `MT_WC : `MT_UC;
			`MT_WC: return `MT_WC;
			`MT_WP: return (r == `MT_WP || r == `MT_WB) ? `MT_WP : `MT_UC;
			`MT_WT: return (r == `MT_WB) ? `MT_WT : r;
			default: return r;
		endcase
	endfunction

	// Expected access policy for a type
	function automatic logic [8:0] pol(input logic [2:0] t);
		case (t)
			`MT_WC: return 9'h0c1;
			`MT_WT: return 9'h165;
			`MT_WP: return 9'h163;
			`MT_WB: return 9'h17c;
			default: return 9'h001;
		endcase
	endfunction

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Range lookup inputs, changed just after an edge
	task automatic rng(input logic en, input logic fe, input logic fh, input logic [2:0] ft,
		input logic [7:0] vh, input logic [23:0] vt, input logic [2:0] dt, input logic sp);
		@(posedge ref_clk);
		range_enable <= en;
		fixed_enable <= fe;
		fixed_hit <= fh;
		fixed_type <= ft;
		var_hit <= vh;
		var_type <= vt;
		default_type <= dt;
		range_split <= sp;
	endtask

	// One resolve through the translation model, answer judged
	task automatic res(input logic [2:0] idx, input logic [2:0] et, input logic eu);
		logic [2:0] t;
		logic       u;
		logic       ok;
		logic [8:0] a;
		translation_unit_model_inst.issue(idx, t, u, a, ok);
		chk(ok, 1'b1);
		chk(t, et);
		chk(u, eu);
		chk(a, pol(et));
		// Valid is a one-cycle pulse, the type stays until the next answer
		@(posedge ref_clk);
		#1;
		chk(rsp_valid, 1'b0);
		chk(eff_type, et);
	endtask

	// Table write with fault pulse and contents judged
	task automatic wr(input logic [63:0] d, input logic flt, input logic [63:0] e);
		@(posedge ref_clk);
		pat_wr_en <= 1'b1;
		pat_wr_data <= d;
		@(posedge ref_clk);
		pat_wr_en <= 1'b0;
		#1;
		chk(protection_fault, flt);
		chk(pat_rd_data, e);
		@(posedge ref_clk);
		#1;
		chk(protection_fault, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		#1;
		chk(pat_rd_data, 64'h0007040600070406);
		chk(protection_fault, 1'b0);
		chk(rsp_valid, 1'b0);
		$display("test reset done");
	endtask

	// Every range type against all eight indexes of the reset table
	task automatic t_default();
		for (int r = 0; r < 5; r++) begin
			for (int i = 0; i < 8; i++) begin
				rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, rt[r], 1'b0);
				res(3'(i), comb(dp[i % 4], rt[r]), 1'b0);
			end
		end
		$display("test default table done");
	endtask

	// Programmed table, then index selection against several range types
	task automatic t_write();
		wr(64'h0007060504010006, 1'b0, 64'h0007060504010006);
		for (int r = 0; r < 5; r++) begin
			for (int i = 0; i < 8; i++) begin
				rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, rt[r], 1'b0);
				res(3'(i), comb(fp[i], rt[r]), 1'b0);
			end
		end
		$display("test table write done");
	endtask

	// Reserved bits and unsupported codes are refused whole
	task automatic t_fault();
		logic [63:0] bad [4] = '{64'h0007060504010806, 64'h8007060504010006,
			64'h0007060504010002, 64'h0307060504010006};
		for (int i = 0; i < 4; i++) begin
			wr(bad[i], 1'b1, 64'h0007060504010006);
		end
		$display("test fault done");
	endtask

	// Range precedence and overlap, page field zero is write-back
	task automatic t_overlap();
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h05, {8{`MT_WP}}, `MT_WB, 1'b0);
		res(3'h0, `MT_WP, 1'b0);
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h03, {{7{`MT_WB}}, `MT_UC}, `MT_WB, 1'b0);
		res(3'h0, `MT_UC, 1'b0);
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h03, {{7{`MT_WB}}, `MT_WT}, `MT_WB, 1'b0);
		res(3'h0, `MT_WT, 1'b0);
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h03, {{7{`MT_WB}}, `MT_WC}, `MT_WB, 1'b0);
		res(3'h0, `MT_UC, 1'b1);
		rng(1'b1, 1'b1, 1'b1, `MT_WC, 8'hff, {8{`MT_UC}}, `MT_WB, 1'b0);
		res(3'h0, `MT_WC, 1'b0);
		rng(1'b1, 1'b0, 1'b1, `MT_WC, 8'hff, {8{`MT_UC}}, `MT_WB, 1'b0);
		res(3'h0, `MT_UC, 1'b0);
		rng(1'b0, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, `MT_WB, 1'b0);
		res(3'h0, `MT_UC, 1'b0);
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, `MT_WB, 1'b1);
		res(3'h0, `MT_WB, 1'b1);
		$display("test overlap done");
	endtask

	// Write and request on one edge: the request still sees the old table
	task automatic t_same();
		logic [2:0] t;
		logic       u;
		logic       ok;
		logic [8:0] a;
		rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, `MT_WB, 1'b0);
		fork
			translation_unit_model_inst.issue(3'h0, t, u, a, ok);
			wr(64'h0007040600070400, 1'b0, 64'h0007040600070400);
		join
		chk(ok, 1'b1);
		chk(t, `MT_WB);
		chk(a, pol(`MT_WB));
		// Next request takes the new field zero
		res(3'h0, `MT_UC, 1'b0);
		$display("test same-cycle write done");
	endtask

	// Either global control turns caching off
	task automatic t_global();
		for (int i = 1; i < 3; i++) begin
			@(posedge ref_clk);
			{global_cache_disable, global_no_write_through} <= 2'(i);
			rng(1'b1, 1'b0, 1'b0, 3'h0, 8'h0, 24'h0, `MT_WB, 1'b0);
			res(3'h0, `MT_UC, 1'b0);
		end
		$display("test global done");
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_default();
		t_write();
		t_fault();
		t_overlap();
		t_same();
		t_global();
		stop_test();
	end

endmodule // memory_type_resolver_bench

`default_nettype wire
